/* tb_top.sv */
// Self-checking bench for the timer channel block
`timescale 1ns/100ps
`default_nettype none
module tb_top
   import tcp_pkg::*;
;
   logic        core_clk = 1'b0;
   logic        arst_n = 1'b0;
   logic [7:0]  avs_address = 8'h00;
   logic        avs_read = 1'b0;
   logic        avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [31:0] avs_readdata;
   logic        avs_waitrequest;
   logic [1:0]  chan_pin_in, chan_pin_out, chan_out_en, dma_req;
   logic        irq_req;
   logic        gen_en = 1'b0;
   int          num_errors = 0;
   int          n_tests = 0;
   int          dma_cnt = 0;

   tcp_timer_channel tcp_timer_channel_inst (.core_clk, .arst_n, .avs_address, .avs_read,
      .avs_write, .avs_writedata, .avs_byteenable(4'hF), .avs_readdata, .avs_waitrequest,
      .chan_pin_in, .chan_pin_out, .chan_out_en, .irq_req, .dma_req);
   tcp_pin_model tcp_pin_model_inst (.core_clk, .gen_en, .chan_pin_out, .chan_out_en,
      .chan_pin_in);

   initial forever #25 core_clk = ~core_clk;
   always @(posedge core_clk) if (dma_req[0] === 1'b1) dma_cnt <= dma_cnt + 1;

   task automatic give_verdict;
      if (num_errors == 0 && n_tests > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         num_errors++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge core_clk);
   endtask
   // Request held until waitrequest is seen low, then released
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
      avs_address   <= a;
      avs_write     <= w;
      avs_read      <= !w;
      avs_writedata <= d;
      @(posedge core_clk);
      while (avs_waitrequest !== 1'b0) @(posedge core_clk);
      q = avs_readdata;
      avs_write <= 1'b0;
      avs_read  <= 1'b0;
      @(posedge core_clk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask
   task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] e);
      logic [31:0] q;
      bus(1'b0, a, 32'h0, q);
      chk(nm, e, q);
   endtask
   // f packs dma enable, irq enable, output enable and polarity
   function automatic logic [31:0] ccm(input logic [1:0] sel, input logic pe,
                                      input logic [2:0] md, input logic [3:0] f);
      return (32'(f) << CCM_POL) | (32'(md) << CCM_MODE) | (32'(pe) << CCM_PE) | 32'(sel);
   endfunction
   // Whole periods of 16 counts, so the count of high samples is exact
   task automatic duty(input string nm, input int e);
      int h;
      h = 0;
      repeat (64) begin
         @(posedge core_clk);
         h += int'(chan_pin_out[0] === 1'b1);
      end
      chk(nm, 32'(e), 32'(h));
   endtask

   task automatic t_reset;
      rd_chk("arr", OFS_ARR, ARR_RST);
      rd_chk("ctrl", OFS_CTRL, 32'h0);
      rd_chk("unmapped", 8'h3C, 32'h0);
   endtask
   task automatic t_force;
      wr(OFS_CCM1, ccm(SEL_OUT, 1'b0, OCM_FHI, 4'h2));
      tick(3);
      chk("out_en", 32'h1, 32'(chan_out_en[0]));
      chk("forced_hi", 32'h1, 32'(chan_pin_out[0]));
      wr(OFS_CCM1, ccm(SEL_OUT, 1'b0, OCM_FHI, 4'h3));
      tick(3);
      chk("forced_hi_inv", 32'h0, 32'(chan_pin_out[0]));
      wr(OFS_CCM1, ccm(SEL_OUT, 1'b0, OCM_FLO, 4'h2));
      tick(3);
      chk("forced_lo", 32'h0, 32'(chan_pin_out[0]));
   endtask
   task automatic t_match;
      int d0;
      wr(OFS_ARR, 32'h0F);
      wr(OFS_CCR1, 32'h5);
      wr(OFS_CCM1, ccm(SEL_OUT, 1'b0, OCM_FLO, 4'hE));
      d0 = dma_cnt;
      wr(OFS_CTRL, 32'h1);
      tick(40);
      rd_chk("flags", OFS_STATUS, 32'h3);
      chk("irq", 32'h1, 32'(irq_req));
      chk("dma", 32'h1, 32'(dma_cnt > d0));
      chk("still_lo", 32'h0, 32'(chan_pin_out[0]));
      wr(OFS_CCM1, ccm(SEL_OUT, 1'b0, OCM_FLO, 4'h2));
      wr(OFS_STATUS, 32'h0);
      tick(2);
      chk("irq_clr", 32'h0, 32'(irq_req));
   endtask
   task automatic t_ocmode;
      logic [2:0] md[4] = '{OCM_ACT, OCM_HOLD, OCM_INACT, OCM_HOLD};
      logic       ex[4] = '{1'b1, 1'b1, 1'b0, 1'b0};
      int         t;
      logic       p;
      for (int i = 0; i < 4; i++) begin
         wr(OFS_CCM1, ccm(SEL_OUT, 1'b0, md[i], 4'h2));
         tick(20);
         chk("match_action", 32'(ex[i]), 32'(chan_pin_out[0]));
      end
      wr(OFS_CCM1, ccm(SEL_OUT, 1'b0, OCM_TOGL, 4'h2));
      tick(4);
      t = 0;
      p = chan_pin_out[0];
      repeat (64) begin
         @(posedge core_clk);
         t += int'(chan_pin_out[0] !== p);
         p = chan_pin_out[0];
      end
      chk("toggles", 32'h4, 32'(t));
   endtask
   task automatic t_pwm;
      logic [2:0]  md[5] = '{OCM_PWM1, OCM_PWM1, OCM_PWM1, OCM_PWM2, OCM_PWM2};
      logic [31:0] cv[5] = '{32'h4, 32'h20, 32'h0, 32'h0, 32'h4};
      int          ex[5] = '{16, 64, 0, 64, 48};
      for (int i = 0; i < 5; i++) begin
         wr(OFS_CCR1, cv[i]);
         wr(OFS_CCM1, ccm(SEL_OUT, 1'b0, md[i], 4'h2));
         tick(4);
         duty("pwm_up", ex[i]);
      end
      // Stopped counter parked above the old shadow, so no overflow refresh
      wr(OFS_CTRL, 32'h0);
      wr(OFS_CNT, 32'h8);
      wr(OFS_CCM1, ccm(SEL_OUT, 1'b1, OCM_PWM1, 4'h2));
      wr(OFS_CCR1, 32'h20);
      tick(4);
      duty("preload_held", 0);
      wr(OFS_EVENT, 32'h1);
      tick(4);
      duty("preload_loaded", 64);
      wr(OFS_CTRL, 32'h3);
      tick(4);
      duty("pwm_down_full", 64);
      wr(OFS_CCR1, 32'h4);
      wr(OFS_EVENT, 32'h1);
      tick(4);
      duty("pwm_down", 20);
   endtask
   task automatic t_center;
      wr(OFS_CTRL, 32'h2);
      wr(OFS_CTRL, 32'h6);
      wr(OFS_EVENT, 32'h1);
      wr(OFS_CNT, 32'h0);
      rd_chk("dir_zero", OFS_CTRL, 32'h4);
      wr(OFS_CNT, 32'h20);
      rd_chk("dir_above", OFS_CTRL, 32'h4);
      wr(OFS_CNT, 32'h0F);
      rd_chk("dir_limit", OFS_CTRL, 32'h6);
      wr(OFS_CTRL, 32'h2);
      wr(OFS_CTRL, 32'h0);
   endtask
   task automatic t_pwin;
      logic [31:0] c1, c2;
      wr(OFS_ARR, 32'hFFFF);
      wr(OFS_CCM1, ccm(SEL_OWN, 1'b0, OCM_HOLD, 4'h2));
      wr(OFS_CCM2, ccm(2'h2, 1'b0, OCM_HOLD, 4'h3));
      wr(OFS_SLAVE, 32'(SMS_RESET) | (32'(TS_EDGE1) << SLV_TS));
      wr(OFS_EVENT, 32'h1);
      wr(OFS_STATUS, 32'h0);
      wr(OFS_CTRL, 32'h1);
      gen_en <= 1'b1;
      tick(240);
      bus(1'b0, OFS_CCR1, 32'h0, c1);
      bus(1'b0, OFS_CCR2, 32'h0, c2);
      chk("low_time", 32'd30, c1 - c2);
      rd_chk("cap_flags", OFS_STATUS, 32'h3);
   endtask

   initial begin
      tick(6);
      arst_n <= 1'b1;
      tick(4);
      t_reset;
      t_force;
      t_match;
      t_ocmode;
      t_pwm;
      t_center;
      t_pwin;
      give_verdict;
   end
   initial begin
      tick(20000);
      num_errors++;
      give_verdict;
   end
endmodule
`default_nettype wire

/* tcp_pin_model.sv */
// Pin partner: pulse source on pin 0, pull-down load on pin 1
`timescale 1ns/100ps
`default_nettype none
module tcp_pin_model #(
   parameter int HI_CYC = 10,
   parameter int LO_CYC = 30
) (
   // Clock and source control
   input  wire logic       core_clk,
   input  wire logic       gen_en,
   // Pins
   input  wire logic [1:0] chan_pin_out,
   input  wire logic [1:0] chan_out_en,
   output logic [1:0]      chan_pin_in
);
   logic wave_q = 1'b0;
   int   cnt_q  = 0;
   // Source stays low between runs so no stray edge reaches a capture
   always_ff @(posedge core_clk) begin
      cnt_q  <= gen_en ? (cnt_q + 1) % (HI_CYC + LO_CYC) : 0;
      wave_q <= gen_en && (cnt_q < HI_CYC);
   end
   // An undriven pin 0 takes the pulse source, an undriven pin 1 is pulled low
   assign chan_pin_in[0] = chan_out_en[0] ? chan_pin_out[0] : wave_q;
   assign chan_pin_in[1] = chan_out_en[1] ? chan_pin_out[1] : 1'b0;
endmodule
`default_nettype wire

/* tcp_pkg.sv */
// Shared constants for the timer capture/compare channel block
package tcp_pkg;

   // Register byte offsets
   localparam logic [7:0] OFS_CTRL   = 8'h00;
   localparam logic [7:0] OFS_SLAVE  = 8'h04;
   localparam logic [7:0] OFS_STATUS = 8'h08;
   localparam logic [7:0] OFS_EVENT  = 8'h0C;
   localparam logic [7:0] OFS_CNT    = 8'h10;
   localparam logic [7:0] OFS_ARR    = 8'h14;
   localparam logic [7:0] OFS_CCM1   = 8'h18;
   localparam logic [7:0] OFS_CCM2   = 8'h1C;
   localparam logic [7:0] OFS_CCR1   = 8'h20;
   localparam logic [7:0] OFS_CCR2   = 8'h24;

   // Control register fields
   localparam int CTRL_EN   = 0;
   localparam int CTRL_DIR  = 1;
   localparam int CTRL_CMS  = 2;
   localparam int CTRL_RELOAD_PRELOAD_ENABLE = 4;
   localparam int CTRL_DSEL = 5;

   // Slave register fields
   localparam int SLV_SMS = 0;
   localparam int SLV_TS  = 4;

   // Channel mode register fields
   localparam int CCM_SEL  = 0;
   localparam int CCM_PE   = 2;
   localparam int CCM_MODE = 4;
   localparam int CCM_POL  = 8;
   localparam int CCM_OE   = 9;
   localparam int CCM_IE   = 10;
   localparam int CCM_DE   = 11;
   localparam int CCM_W    = 12;

   // Event register field
   localparam int EVT_UG = 0;

   // Reset values
   localparam logic [31:0] ARR_RST  = 32'h0000FFFF;
   localparam logic [5:0]  CTRL_RST = 6'h00;

   // Encodings
   localparam logic [1:0] SEL_OUT   = 2'h0;
   localparam logic [1:0] SEL_OWN   = 2'h1;
   localparam logic [1:0] CMS_EDGE  = 2'h0;
   localparam logic [1:0] CMS_DOWN  = 2'h1;
   localparam logic [1:0] CMS_UP    = 2'h2;
   localparam logic [2:0] OCM_HOLD  = 3'h0;
   localparam logic [2:0] OCM_ACT   = 3'h1;
   localparam logic [2:0] OCM_INACT = 3'h2;
   localparam logic [2:0] OCM_TOGL  = 3'h3;
   localparam logic [2:0] OCM_FLO   = 3'h4;
   localparam logic [2:0] OCM_FHI   = 3'h5;
   localparam logic [2:0] OCM_PWM1  = 3'h6;
   localparam logic [2:0] OCM_PWM2  = 3'h7;
   localparam logic [2:0] SMS_RESET = 3'h4;
   localparam logic [2:0] TS_EDGE1  = 3'h5;
   localparam logic [2:0] TS_EDGE2  = 3'h6;

endpackage

/* tcp_ref_gen.sv */
// Reference waveform generator for one compare channel
`timescale 1ns/100ps
`default_nettype none
module tcp_ref_gen
   import tcp_pkg::*;
#(
   parameter int CNT_W = 16
) (
   // Clock and reset
   input  wire logic             core_clk,
   input  wire logic             rst_n,
   // Channel settings and counter state
   input  wire logic [2:0]       mode,
   input  wire logic             match,
   input  wire logic             cnt_down,
   input  wire logic [CNT_W-1:0] cnt,
   input  wire logic [CNT_W-1:0] ccr,
   input  wire logic [CNT_W-1:0] arr,
   // Active-high reference
   output logic                  ref_q
);

   logic pwm1;
   logic ref_d;

   always_comb begin
      // Direction decides whether a count equal to the compare is active
      pwm1 = cnt_down ? (cnt <= ccr) : (cnt < ccr);
      if (ccr > arr) begin
         pwm1 = 1'b1;
      end
   end

   // Refresh events never enter here, so compare modes ignore them
   always_comb begin
      unique case (mode)
         OCM_HOLD:  ref_d = ref_q;
         OCM_ACT:   ref_d = match ? 1'b1 : ref_q;
         OCM_INACT: ref_d = match ? 1'b0 : ref_q;
         OCM_TOGL:  ref_d = match ? ~ref_q : ref_q;
         OCM_FLO:   ref_d = 1'b0;
         OCM_FHI:   ref_d = 1'b1;
         OCM_PWM1:  ref_d = pwm1;
         OCM_PWM2:  ref_d = ~pwm1;
      endcase
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         ref_q <= 1'b0;
      end else begin
         ref_q <= ref_d;
      end
   end

endmodule
`default_nettype wire

/* tcp_timer_channel.sv */
// Timer counter with two capture/compare channels behind an Avalon-MM slave
`timescale 1ns/100ps
`default_nettype none
module tcp_timer_channel
   import tcp_pkg::*;
#(
   parameter int CNT_W = 16
) (
   // Clock and reset
   input  wire logic        core_clk,
   input  wire logic        arst_n,
   // Avalon-MM slave
   input  wire logic [7:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   input  wire logic [3:0]  avs_byteenable,
   output logic [31:0]      avs_readdata,
   output logic             avs_waitrequest,
   // Channel pins
   input  wire logic [1:0]  chan_pin_in,
   output logic [1:0]       chan_pin_out,
   output logic [1:0]       chan_out_en,
   // Requests
   output logic             irq_req,
   output logic [1:0]       dma_req
);

   localparam int NCH = 2;

   function automatic logic [31:0] merge(input logic [31:0] old_v,
                                         input logic [31:0] new_v,
                                         input logic [3:0]  be);
      logic [31:0] m;
      m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
      return (old_v & ~m) | (new_v & m);
   endfunction

   logic [1:0]        rst_sync_q;
   logic              rst_n;
   logic              ack_q;
   logic [31:0]       rdata_q;
   logic              wr;
   logic [5:0]        ctrl_q;
   logic [6:0]        slave_q;
   logic [CCM_W-1:0]  ccm_q [NCH];
   logic [CNT_W-1:0]  cnt_q;
   logic [CNT_W-1:0]  cnt_d;
   logic              dir_q;
   logic              dir_d;
   logic [CNT_W-1:0]  arr_pre_q;
   logic [CNT_W-1:0]  arr_act_q;
   logic [CNT_W-1:0]  ccr_pre_q [NCH];
   logic [CNT_W-1:0]  ccr_sh_q [NCH];
   logic [NCH-1:0]    flag_q;
   logic [NCH-1:0]    pin_s1_q;
   logic [NCH-1:0]    pin_s2_q;
   logic [NCH-1:0]    pin_s3_q;
   logic [NCH-1:0]    rise;
   logic [NCH-1:0]    fall;
   logic [NCH-1:0]    filt_edge;
   logic [NCH-1:0]    cap;
   logic [NCH-1:0]    match;
   logic [NCH-1:0]    flag_match;
   logic [NCH-1:0]    ref_wave;
   logic [NCH-1:0]    pin_out_q;
   logic [NCH-1:0]    dma_q;
   logic              run;
   logic              center;
   logic              ovf;
   logic              force_ug;
   logic              trig;
   logic              refresh_event;
   logic              cnt_wr;
   logic [CNT_W-1:0]  wval;

   // Reset release through two flops
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         rst_sync_q <= 2'h0;
      end else begin
         rst_sync_q <= {rst_sync_q[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_q[1];

   // One wait state, then the access completes
   assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;
   assign wr              = avs_write & ack_q;
   assign wval            = avs_writedata[CNT_W-1:0];
   assign avs_readdata    = rdata_q;

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         ack_q   <= 1'b0;
         rdata_q <= 32'h0;
      end else begin
         ack_q <= (avs_read | avs_write) & ~ack_q;
         if (avs_read && !ack_q) begin
            unique case (avs_address)
               OFS_CTRL:   rdata_q <= {26'h0, ctrl_q[5:2], dir_q, ctrl_q[CTRL_EN]};
               OFS_SLAVE:  rdata_q <= {25'h0, slave_q};
               OFS_STATUS: rdata_q <= {30'h0, flag_q};
               OFS_CNT:    rdata_q <= 32'(cnt_q);
               OFS_ARR:    rdata_q <= 32'(arr_pre_q);
               OFS_CCM1:   rdata_q <= 32'(ccm_q[0]);
               OFS_CCM2:   rdata_q <= 32'(ccm_q[1]);
               OFS_CCR1:   rdata_q <= 32'(ccr_pre_q[0]);
               OFS_CCR2:   rdata_q <= 32'(ccr_pre_q[1]);
               default:    rdata_q <= 32'h0;
            endcase
         end
      end
   end

   // Configuration registers
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_q  <= CTRL_RST;
         slave_q <= 7'h0;
         ccm_q   <= '{default: '0};
      end else if (wr) begin
         if (avs_address == OFS_CTRL) begin
            ctrl_q <= 6'(merge(32'(ctrl_q), avs_writedata, avs_byteenable));
         end
         if (avs_address == OFS_SLAVE) begin
            slave_q <= 7'(merge(32'(slave_q), avs_writedata, avs_byteenable));
         end
         if (avs_address == OFS_CCM1) begin
            ccm_q[0] <= CCM_W'(merge(32'(ccm_q[0]), avs_writedata, avs_byteenable));
         end
         if (avs_address == OFS_CCM2) begin
            ccm_q[1] <= CCM_W'(merge(32'(ccm_q[1]), avs_writedata, avs_byteenable));
         end
      end
   end

   // Pin synchronisers and edge detection
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         pin_s1_q <= '0;
         pin_s2_q <= '0;
         pin_s3_q <= '0;
      end else begin
         pin_s1_q <= chan_pin_in;
         pin_s2_q <= pin_s1_q;
         pin_s3_q <= pin_s2_q;
      end
   end
   assign rise = pin_s2_q & ~pin_s3_q;
   assign fall = ~pin_s2_q & pin_s3_q;

   always_comb begin
      for (int i = 0; i < NCH; i++) begin
         filt_edge[i] = ccm_q[i][CCM_POL] ? fall[i] : rise[i];
         // Own pin for select 01, the other channel's pin otherwise
         if (ccm_q[i][CCM_SEL+:2] == SEL_OWN) begin
            cap[i] = ccm_q[i][CCM_POL] ? fall[i] : rise[i];
         end else begin
            cap[i] = ccm_q[i][CCM_POL] ? fall[1-i] : rise[1-i];
         end
         cap[i] = cap[i] & ccm_q[i][CCM_OE] & (ccm_q[i][CCM_SEL+:2] != SEL_OUT);
      end
   end

   // Only the two channel edges can reach the reset-mode slave
   assign trig = (slave_q[SLV_SMS+:3] == SMS_RESET) &
                 (((slave_q[SLV_TS+:3] == TS_EDGE1) & filt_edge[0]) |
                  ((slave_q[SLV_TS+:3] == TS_EDGE2) & filt_edge[1]));

   assign run      = ctrl_q[CTRL_EN];
   assign center   = ctrl_q[CTRL_CMS+:2] != CMS_EDGE;
   assign force_ug = wr & (avs_address == OFS_EVENT) & avs_byteenable[0] &
                     avs_writedata[EVT_UG];
   assign cnt_wr   = wr & (avs_address == OFS_CNT);
   assign refresh_event = ovf | force_ug | trig;

   // Counter and direction
   always_comb begin
      ovf   = 1'b0;
      cnt_d = cnt_q;
      dir_d = dir_q;
      if (run && !cnt_wr) begin
         if (!dir_q) begin
            if (cnt_q >= arr_act_q) begin
               ovf = 1'b1;
               if (center) begin
                  dir_d = 1'b1;
                  cnt_d = cnt_q - 1'b1;
               end else begin
                  cnt_d = '0;
               end
            end else begin
               cnt_d = cnt_q + 1'b1;
            end
         end else begin
            if (cnt_q == '0) begin
               ovf = 1'b1;
               if (center) begin
                  dir_d = 1'b0;
                  cnt_d = cnt_q + 1'b1;
               end else begin
                  cnt_d = arr_act_q;
               end
            end else begin
               cnt_d = cnt_q - 1'b1;
            end
         end
      end
      if (cnt_wr) begin
         cnt_d = wval;
         // No refresh from a counter write; only 0 or the limit steer direction
         if (center && wval == '0) begin
            dir_d = 1'b0;
         end else if (center && wval == arr_act_q) begin
            dir_d = 1'b1;
         end
      end
      if (wr && avs_address == OFS_CTRL && !center && avs_byteenable[0]) begin
         dir_d = avs_writedata[CTRL_DIR];
      end
      if (force_ug || trig) begin
         cnt_d = dir_d ? arr_act_q : '0;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_q <= '0;
         dir_q <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         dir_q <= dir_d;
      end
   end

   // Auto-reload preload and active value
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         arr_pre_q <= ARR_RST[CNT_W-1:0];
         arr_act_q <= ARR_RST[CNT_W-1:0];
      end else begin
         if (wr && avs_address == OFS_ARR) begin
            arr_pre_q <= wval;
            if (!ctrl_q[CTRL_RELOAD_PRELOAD_ENABLE]) begin
               arr_act_q <= wval;
            end
         end else if (refresh_event) begin
            arr_act_q <= arr_pre_q;
         end
      end
   end

   // Compare preload, shadow and capture storage
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         ccr_pre_q <= '{default: '0};
         ccr_sh_q  <= '{default: '0};
      end else begin
         for (int i = 0; i < NCH; i++) begin
            if (cap[i]) begin
               ccr_pre_q[i] <= cnt_q;
            end else if (wr && ccm_q[i][CCM_SEL+:2] == SEL_OUT &&
                         avs_address == (i == 0 ? OFS_CCR1 : OFS_CCR2)) begin
               ccr_pre_q[i] <= wval;
               if (!ccm_q[i][CCM_PE]) begin
                  ccr_sh_q[i] <= wval;
               end
            end else if (refresh_event && ccm_q[i][CCM_PE]) begin
               ccr_sh_q[i] <= ccr_pre_q[i];
            end
         end
      end
   end

   // Compare runs in every output mode, forced ones included
   always_comb begin
      for (int i = 0; i < NCH; i++) begin
         match[i] = run & (ccm_q[i][CCM_SEL+:2] == SEL_OUT) &
                    (cnt_q == ccr_sh_q[i]);
         unique case (ctrl_q[CTRL_CMS+:2])
            CMS_EDGE: flag_match[i] = match[i];
            CMS_DOWN: flag_match[i] = match[i] & dir_q;
            CMS_UP:   flag_match[i] = match[i] & ~dir_q;
            default:  flag_match[i] = match[i];
         endcase
      end
   end

   // Flags clear on a written zero; a simultaneous set wins
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         flag_q <= '0;
      end else begin
         for (int i = 0; i < NCH; i++) begin
            if (flag_match[i] || cap[i]) begin
               flag_q[i] <= 1'b1;
            end else if (wr && avs_address == OFS_STATUS && avs_byteenable[0] &&
                         !avs_writedata[i]) begin
               flag_q[i] <= 1'b0;
            end
         end
      end
   end

   assign irq_req = |(flag_q & {ccm_q[1][CCM_IE], ccm_q[0][CCM_IE]});

   // DMA request on the match or on the refresh, as selected
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         dma_q <= '0;
      end else begin
         for (int i = 0; i < NCH; i++) begin
            dma_q[i] <= ccm_q[i][CCM_DE] &
                        (ctrl_q[CTRL_DSEL] ? refresh_event : flag_match[i]);
         end
      end
   end
   assign dma_req = dma_q;

   for (genvar g = 0; g < NCH; g++) begin : g_ch
      tcp_ref_gen #(
         .CNT_W(CNT_W)
      ) u_ref (
         .core_clk (core_clk),
         .rst_n    (rst_n),
         .mode     (ccm_q[g][CCM_MODE+:3]),
         .match    (match[g]),
         .cnt_down (dir_q),
         .cnt      (cnt_q),
         .ccr      (ccr_sh_q[g]),
         .arr      (arr_act_q),
         .ref_q    (ref_wave[g])
      );
   end

   // Polarity applied at the end of the chain
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         pin_out_q <= '0;
      end else begin
         for (int i = 0; i < NCH; i++) begin
            pin_out_q[i] <= ref_wave[i] ^ ccm_q[i][CCM_POL];
         end
      end
   end

   always_comb begin
      for (int i = 0; i < NCH; i++) begin
         chan_out_en[i]  = ccm_q[i][CCM_OE] & (ccm_q[i][CCM_SEL+:2] == SEL_OUT);
         chan_pin_out[i] = chan_out_en[i] & pin_out_q[i];
      end
   end

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);

   a_force_high_ref: assert property (
      ccm_q[0][CCM_MODE+:3] == OCM_FHI && $stable(ccm_q[0])
      |=> ref_wave[0] ##1 pin_out_q[0] == !$past(ccm_q[0][CCM_POL]))
      else $error("forced high mode did not drive reference high");
   a_force_low_ref: assert property (
      ccm_q[1][CCM_MODE+:3] == OCM_FLO |=> !ref_wave[1])
      else $error("forced low mode did not drive reference low");
   a_forced_still_flags: assert property (
      match[0] && ccm_q[0][CCM_MODE+:3] == OCM_FHI && !center |=> flag_q[0])
      else $error("forced output lost its match flag");
   a_toggle_on_match: assert property (
      match[0] && ccm_q[0][CCM_MODE+:3] == OCM_TOGL |=> ref_wave[0] != $past(ref_wave[0]))
      else $error("toggle mode did not invert reference on match");
   a_match_sets_flag: assert property (
      flag_match[1] |=> flag_q[1])
      else $error("match did not set flag");
   a_irq_on_match: assert property (
      flag_match[0] && ccm_q[0][CCM_IE] && !(wr && avs_address == OFS_CCM1) |=> irq_req)
      else $error("enabled match did not raise interrupt");
   a_dma_on_match: assert property (
      flag_match[0] && ccm_q[0][CCM_DE] && !ctrl_q[CTRL_DSEL] |=> dma_req[0] ##1 !dma_req[0])
      else $error("DMA request was not a single pulse on match");
   a_preload_off_imm: assert property (
      wr && avs_address == OFS_CCR1 && ccm_q[0][CCM_SEL+:2] == SEL_OUT &&
      !ccm_q[0][CCM_PE] && !cap[0] |=> ccr_sh_q[0] == $past(wval))
      else $error("compare write without preload did not apply at once");
   a_preload_hold: assert property (
      ccm_q[0][CCM_PE] && !refresh_event |=> $stable(ccr_sh_q[0]))
      else $error("preloaded shadow changed without refresh");
   a_pwm1_up_high: assert property (
      ccm_q[0][CCM_MODE+:3] == OCM_PWM1 && !dir_q && cnt_q < ccr_sh_q[0] |=> ref_wave[0])
      else $error("PWM1 upcount reference low below compare");
   a_pwm1_down_low: assert property (
      ccm_q[0][CCM_MODE+:3] == OCM_PWM1 && dir_q && cnt_q > ccr_sh_q[0] &&
      ccr_sh_q[0] <= arr_act_q |=> !ref_wave[0])
      else $error("PWM1 downcount reference high above compare");
   a_pwm2_inverse: assert property (
      ccm_q[1][CCM_MODE+:3] == OCM_PWM2 && !dir_q && cnt_q < ccr_sh_q[1] &&
      ccr_sh_q[1] <= arr_act_q |=> !ref_wave[1])
      else $error("PWM2 reference not inverse of PWM1");
   a_count_up_step: assert property (
      run && !dir_q && !cnt_wr && !force_ug && !trig && cnt_q < arr_act_q
      |=> cnt_q == $past(cnt_q) + 1'b1)
      else $error("upcount step wrong");
   a_center_dir_keep: assert property (
      center && cnt_wr && wval > arr_act_q && !force_ug |=> dir_q == $past(dir_q))
      else $error("counter write above limit changed direction");

   c_forced_high: cover property (ccm_q[0][CCM_MODE+:3] == OCM_FHI ##1 flag_match[0]);
   c_pwm_center: cover property (center && ccm_q[0][CCM_MODE+:3] == OCM_PWM1 && ovf);
   c_pulse_width: cover property (trig ##[1:50] cap[1]);

endmodule
`default_nettype wire
